// ### logic/wdt_pkg.sv
/*
  Shared constants and types of the windowed watchdog timer: clock rates,
  divider counts, APB register offsets, field positions and reset values.
  Assumes a single 10 MHz system clock and 32-bit APB data.
*/
package wdt_pkg;

  // System clock and nominal low-power RC oscillator rate
  localparam int unsigned SYS_CLK_HZ = 10_000_000;
  localparam int unsigned RC_OSC_HZ = 31_000;

  // System cycles per oscillator tick, rounded down to whole cycles
  localparam int unsigned RC_TICK_DIV = SYS_CLK_HZ / RC_OSC_HZ;
  localparam int DIV_W = 9;
  localparam logic [DIV_W-1:0] RC_TICK_DIV_LAST = DIV_W'(RC_TICK_DIV - 1);

  // Prescaler widths in bits: divide by 32 or by 128
  localparam logic [4:0] PRE_SHIFT_SHORT = 5'h05;
  localparam logic [4:0] PRE_SHIFT_LONG = 5'h07;

  // Joint prescaler and postscaler count: 7 + 15 bits at most
  localparam int CNT_W = 22;

  // APB register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_CFG = 8'h04;
  localparam logic [7:0] OFS_STAT = 8'h08;
  localparam logic [7:0] OFS_COUNT = 8'h0C;

  // Control register fields
  localparam int CTRL_SOFT_EN_BIT = 0;

  // Configuration register fields
  localparam int CFG_POST_LSB = 0;
  localparam int CFG_PRESEL_BIT = 4;
  localparam int CFG_WINDOW_DIS_BIT = 6;
  localparam int CFG_HARDEN_BIT = 7;
  localparam logic [31:0] CFG_RESET = 32'h0000_0050;

  // Status register fields; bits 0 to 2 and 5 clear by writing one
  localparam int STAT_TIMEOUT_BIT = 0;
  localparam int STAT_SLEEP_BIT = 1;
  localparam int STAT_IDLE_BIT = 2;
  localparam int STAT_WINDOW_BIT = 3;
  localparam int STAT_RUNNING_BIT = 4;
  localparam int STAT_EARLY_BIT = 5;

  // Count register fields
  localparam int COUNT_MODE_LSB = 24;

  // Power modes of the device core
  typedef enum logic [1:0] {
    MODE_RUN = 2'b00,
    MODE_SLEEP = 2'b01,
    MODE_IDLE = 2'b10
  } mode_e;

endpackage

// ### logic/low_power_rc_osc_tick_gen.sv
/*
  Stand-in for the low-power RC oscillator: a one-cycle enable pulse at the
  nominal oscillator rate, derived from the system clock.
  Assumes sys_clk_i at the rate given in the package.
*/
`timescale 1ns/1ps
`default_nettype none

module rc_tick_gen
  import wdt_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_i,
  // Oscillator control
  input wire logic enable_i,
  output logic tick_o
);

  typedef struct packed {
    logic [DIV_W-1:0] div;
    logic tick;
  } tick_state_s;

  tick_state_s s_q;
  tick_state_s s_d;

  // Divider stops and rewinds while the oscillator is off to save power
  always_comb begin
    s_d = s_q;
    s_d.tick = 1'b0;
    if (!enable_i) begin
      s_d.div = '0;
    end else if (s_q.div == RC_TICK_DIV_LAST) begin
      s_d.div = '0;
      s_d.tick = 1'b1;
    end else begin
      s_d.div = s_q.div + 1'b1;
    end
  end

  // State register
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign tick_o = s_q.tick;

endmodule // rc_tick_gen

`default_nettype wire

// ### logic/windowed_watchdog_timer.sv
/*
  Windowed watchdog timer with APB register access, sleep and idle wake-up
  and a one-cycle watchdog reset request.
  Assumes the core signals instruction events as one-cycle pulses that are
  synchronous to sys_clk_i, and that an external reset controller turns the
  reset request into a device reset.
  Counting runs on the one system clock; the oscillator is an enable pulse.
*/
`timescale 1ns/1ps
`default_nettype none

// What this block does
// - Clock from the 31 kHz oscillator, switched on whenever the watchdog runs.
// - Prescaler divides by 32 or by 128, chosen by a configuration bit.
// - Prescaler alone gives about 1 ms or about 4 ms.
// - Postscaler adds one of 16 ratios from 1:1 to 1:32,768.
// - Counters clear on reset, clock switch, power-save entry and exit, clear.
// - An enabled watchdog keeps counting in sleep and idle.
// - Time-out in sleep or idle wakes the core; software clears mode bits.
// - Time-out sets a sticky flag that software or a device reset clears.
// - In window mode a clear before the last quarter causes a reset.
// - Window mode is on when the window-disable bit is zero.
// - Hard enable bit set keeps the watchdog running always.
// - Otherwise the software enable bit starts and stops it.
// - Every device reset clears the software enable bit.
module windowed_watchdog_timer
  import wdt_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_i,
  // APB slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // Core instruction and clock events
  input wire logic watchdog_clear_instr_i,
  input wire logic power_save_instr_i,
  input wire logic power_save_idle_i,
  input wire logic wake_event_i,
  input wire logic clock_switch_done_i,
  // Watchdog results
  output logic wdt_reset_o,
  output logic wake_o,
  output logic low_power_rc_osc_en_o,
  output logic [1:0] power_mode_o
);

  typedef struct packed {
    // Configuration and software enable
    logic soft_enable_bit;
    logic [3:0] postscale_select_cfg;
    logic prescale_select_cfg;
    logic window_disable_cfg;
    logic hard_enable_cfg;
    // Sticky status flags, cleared by writing one
    logic timeout_flag;
    logic sleep_flag;
    logic idle_flag;
    logic early_flag;
    // Power mode and joint prescaler and postscaler count
    mode_e mode;
    logic [CNT_W-1:0] count;
    // One-cycle pulses and oscillator enable
    logic wdt_reset;
    logic wake;
    logic osc_en;
    // Registered bus answer
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } wdt_state_s;

  wdt_state_s s_q;
  wdt_state_s s_d;

  logic osc_tick;

  // Oscillator ticks at the nominal rate while enabled; its phase is not
  // rewound by a watchdog clear, so the first period after a clear may be
  // up to one tick shorter than nominal
  rc_tick_gen rc_tick_gen_inst (
    .sys_clk_i(sys_clk_i),
    .rst_i(rst_i),
    .enable_i(s_q.osc_en),
    .tick_o(osc_tick)
  );

  // Decoded enables and period figures
  logic running;
  logic [4:0] pre_shift;
  logic [4:0] shift;
  logic [CNT_W:0] period;
  logic [CNT_W-1:0] last_count;
  logic [CNT_W-1:0] window_start;
  logic window_open;
  logic timeout_evt;
  // Decoded instruction events
  logic clear_req;
  logic early_clear;
  logic good_clear;
  logic entering;
  logic leaving;
  // Joint rewind of prescaler and postscaler
  logic counter_clear;

  // Enable logic and time-out arithmetic. The period is a power of two of
  // oscillator ticks, so one shifter replaces the two cascaded dividers;
  // the trade-off is that a ratio change acts on the running count
  // instead of waiting for the next restart
  always_comb begin
    running = s_q.hard_enable_cfg | s_q.soft_enable_bit;
    if (s_q.prescale_select_cfg) begin
      pre_shift = PRE_SHIFT_LONG;
    end else begin
      pre_shift = PRE_SHIFT_SHORT;
    end
    shift = pre_shift + {1'b0, s_q.postscale_select_cfg};
    period = (CNT_W+1)'(1) << shift;
    last_count = CNT_W'(period - (CNT_W+1)'(1));
    // Last quarter starts at three quarters of the period
    // Integer shift rounds the window length down, never opening it early
    window_start = last_count - (last_count >> 2);
    window_open = (s_q.count >= window_start);
    // A larger count can remain after a shorter ratio is written
    timeout_evt = running & osc_tick & (s_q.count >= last_count);
  end

  // Instruction events; the core issues at most one of them in a cycle
  always_comb begin
    // Clear instruction only counts during normal execution
    clear_req = watchdog_clear_instr_i & (s_q.mode == MODE_RUN);
    early_clear = clear_req & running & ~s_q.window_disable_cfg & ~window_open;
    good_clear = clear_req & ~early_clear;
    entering = power_save_instr_i & (s_q.mode == MODE_RUN);
    leaving = (s_q.mode != MODE_RUN) & (timeout_evt | wake_event_i);
  end

  // Everything that rewinds the prescaler and postscaler
  // A watchdog reset restarts the count in the edge that raises the request
  always_comb begin
    counter_clear = clock_switch_done_i | entering | leaving | good_clear;
    // A watchdog reset is a device reset too
    counter_clear = counter_clear | early_clear;
    counter_clear = counter_clear | (timeout_evt & (s_q.mode == MODE_RUN));
    // Stopped watchdog restarts from zero
    counter_clear = counter_clear | ~running;
  end

  // Next state: bus access first, hardware events after so that they win
  // over a software write in the same cycle; a flag that is set and
  // cleared at once therefore reads back as set
  always_comb begin
    s_d = s_q;
    s_d.wdt_reset = 1'b0;
    s_d.wake = 1'b0;

    // APB setup cycle: decode, fetch read data, answer next cycle
    // Read data is latched at setup so the access cycle sees a stable word
    if (psel_i && !penable_i) begin
      s_d.pready = 1'b1;
      s_d.pslverr = 1'b0;
      s_d.prdata = '0;
      unique case (paddr_i)
        OFS_CTRL: begin
          s_d.prdata[CTRL_SOFT_EN_BIT] = s_q.soft_enable_bit;
        end
        OFS_CFG: begin
          s_d.prdata[CFG_POST_LSB +: 4] = s_q.postscale_select_cfg;
          s_d.prdata[CFG_PRESEL_BIT] = s_q.prescale_select_cfg;
          s_d.prdata[CFG_WINDOW_DIS_BIT] = s_q.window_disable_cfg;
          s_d.prdata[CFG_HARDEN_BIT] = s_q.hard_enable_cfg;
        end
        OFS_STAT: begin
          s_d.prdata[STAT_TIMEOUT_BIT] = s_q.timeout_flag;
          s_d.prdata[STAT_SLEEP_BIT] = s_q.sleep_flag;
          s_d.prdata[STAT_IDLE_BIT] = s_q.idle_flag;
          s_d.prdata[STAT_WINDOW_BIT] = window_open;
          s_d.prdata[STAT_RUNNING_BIT] = running;
          s_d.prdata[STAT_EARLY_BIT] = s_q.early_flag;
        end
        OFS_COUNT: begin
          s_d.prdata[CNT_W-1:0] = s_q.count;
          s_d.prdata[COUNT_MODE_LSB +: 2] = s_q.mode;
        end
        default: begin
          // Unmapped address: error answer, reads as zero
          s_d.pslverr = 1'b1;
        end
      endcase
    end else if (s_q.pready) begin
      // Access phase ends here; release the answer
      s_d.pready = 1'b0;
      s_d.pslverr = 1'b0;
      s_d.prdata = '0;
    end

    // Writes take effect at the access edge with pready high
    if (psel_i && penable_i && s_q.pready && pwrite_i && !s_q.pslverr) begin
      unique case (paddr_i)
        OFS_CTRL: begin
          s_d.soft_enable_bit = pwdata_i[CTRL_SOFT_EN_BIT];
        end
        OFS_CFG: begin
          s_d.postscale_select_cfg = pwdata_i[CFG_POST_LSB +: 4];
          s_d.prescale_select_cfg = pwdata_i[CFG_PRESEL_BIT];
          s_d.window_disable_cfg = pwdata_i[CFG_WINDOW_DIS_BIT];
          s_d.hard_enable_cfg = pwdata_i[CFG_HARDEN_BIT];
        end
        OFS_STAT: begin
          // Write one to clear; a set in this cycle still wins below
          if (pwdata_i[STAT_TIMEOUT_BIT]) begin
            s_d.timeout_flag = 1'b0;
          end
          if (pwdata_i[STAT_SLEEP_BIT]) begin
            s_d.sleep_flag = 1'b0;
          end
          if (pwdata_i[STAT_IDLE_BIT]) begin
            s_d.idle_flag = 1'b0;
          end
          if (pwdata_i[STAT_EARLY_BIT]) begin
            s_d.early_flag = 1'b0;
          end
        end
        default: begin
          // Count register is read only
          s_d.soft_enable_bit = s_q.soft_enable_bit;
        end
      endcase
    end

    if (counter_clear) begin
      s_d.count = '0;
    end else if (osc_tick) begin
      s_d.count = s_q.count + 1'b1;
    end

    // Power mode sequencing
    // Entry and exit both rewind the count through counter_clear above
    unique case (s_q.mode)
      MODE_RUN: begin
        if (entering) begin
          if (power_save_idle_i) begin
            s_d.mode = MODE_IDLE;
            s_d.idle_flag = 1'b1;
          end else begin
            s_d.mode = MODE_SLEEP;
            s_d.sleep_flag = 1'b1;
          end
        end
      end
      MODE_SLEEP, MODE_IDLE: begin
        if (leaving) begin
          s_d.mode = MODE_RUN;
          s_d.wake = 1'b1;
        end
      end
      default: begin
        // Unused code: fall back to normal execution
        s_d.mode = MODE_RUN;
      end
    endcase

    if (timeout_evt) begin
      s_d.timeout_flag = 1'b1;
    end

    if ((timeout_evt && s_q.mode == MODE_RUN) || early_clear) begin
      s_d.wdt_reset = 1'b1;
      s_d.soft_enable_bit = 1'b0;
    end
    if (early_clear) begin
      s_d.early_flag = 1'b1;
    end

    s_d.osc_en = s_d.hard_enable_cfg | s_d.soft_enable_bit;
  end

  // State register; configuration takes its erased-state value at reset
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      s_q.soft_enable_bit <= 1'b0;
      s_q.postscale_select_cfg <= CFG_RESET[CFG_POST_LSB +: 4];
      s_q.prescale_select_cfg <= CFG_RESET[CFG_PRESEL_BIT];
      s_q.window_disable_cfg <= CFG_RESET[CFG_WINDOW_DIS_BIT];
      s_q.hard_enable_cfg <= CFG_RESET[CFG_HARDEN_BIT];
      // Flags, count and pulses start clear
      s_q.timeout_flag <= 1'b0;
      s_q.sleep_flag <= 1'b0;
      s_q.idle_flag <= 1'b0;
      s_q.early_flag <= 1'b0;
      s_q.mode <= MODE_RUN;
      s_q.count <= '0;
      s_q.wdt_reset <= 1'b0;
      s_q.wake <= 1'b0;
      s_q.osc_en <= 1'b0;
      // Bus answer idle
      s_q.prdata <= '0;
      s_q.pready <= 1'b0;
      s_q.pslverr <= 1'b0;
    end else begin
      s_q <= s_d;
    end
  end

  // Outputs come straight from the state register
  // so no combinational path reaches a pin
  assign prdata_o = s_q.prdata;
  assign pready_o = s_q.pready;
  assign pslverr_o = s_q.pslverr;
  assign wdt_reset_o = s_q.wdt_reset;
  assign wake_o = s_q.wake;
  assign low_power_rc_osc_en_o = s_q.osc_en;
  assign power_mode_o = s_q.mode;

endmodule // windowed_watchdog_timer

`default_nettype wire

// ### verification/wdt_checker.sv
/*
  Port checker of the windowed watchdog timer: bus answer timing and
  watchdog pulse rules.
  Assumes it is bound to the top module and sees its ports only.
*/
`timescale 1ns/1ps
`default_nettype none

module wdt_checker
  import wdt_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_i,
  // Bus and events
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] prdata_o,
  input wire logic pready_o,
  input wire logic pslverr_o,
  input wire logic watchdog_clear_instr_i,
  // Results
  input wire logic wdt_reset_o,
  input wire logic wake_o,
  input wire logic low_power_rc_osc_en_o,
  input wire logic [1:0] power_mode_o
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);

  // Zero wait states, one access cycle
  property p_rdy; psel_i && !penable_i |=> pready_o ##1 !pready_o; endproperty
  a_rdy: assert property (p_rdy) else $error("ready not one cycle after setup");
  // Error only with an unmapped address
  property p_err; pready_o |-> pslverr_o == (paddr_i > 8'h0C || paddr_i[1:0] != 2'h0);
  endproperty
  a_err: assert property (p_err) else $error("error flag wrong for address");
  // Read data zero outside access
  property p_idle; !pready_o |-> prdata_o == 32'h0; endproperty
  a_idle: assert property (p_idle) else $error("read data not zero when idle");
  property p_rpulse; wdt_reset_o |=> !wdt_reset_o; endproperty
  a_rpulse: assert property (p_rpulse) else $error("reset pulse too long");
  property p_wpulse; wake_o |=> !wake_o; endproperty
  a_wpulse: assert property (p_wpulse) else $error("wake pulse too long");
  property p_wmode; wake_o |-> $past(power_mode_o) != MODE_RUN; endproperty
  a_wmode: assert property (p_wmode) else $error("wake while running");
  property p_rmode; wdt_reset_o |-> $past(power_mode_o) == MODE_RUN; endproperty
  a_rmode: assert property (p_rmode) else $error("reset from low power");
  property p_stop; wdt_reset_o && !$past(watchdog_clear_instr_i) |->
    $past(low_power_rc_osc_en_o); endproperty
  a_stop: assert property (p_stop) else $error("time-out while stopped");
  property p_osc; $fell(rst_i) |-> !low_power_rc_osc_en_o; endproperty
  a_osc: assert property (p_osc) else $error("oscillator on after reset");

  // Main scenarios
  c_rst: cover property (wdt_reset_o);
  c_wake: cover property (wake_o);
  c_err: cover property (pslverr_o);
endmodule // wdt_checker

`default_nettype wire

// ### verification/windowed_watchdog_timer_bench.sv
/*
  Bench of the windowed watchdog timer: APB register tasks, event pulses,
  period and window checks.
  Assumes the package constants and a 10 MHz clock.
*/
`timescale 1ns/1ps
`default_nettype none

module windowed_watchdog_timer_bench import wdt_pkg::*;;
  logic sys_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic psel = 1'b0, pen = 1'b0, pwr = 1'b0, idle = 1'b0, e;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, r;
  logic [3:0] ev = 4'h0;
  logic pready, pslverr, wrst, wake, osc;
  logic [1:0] mode;
  int n_fail = 0, checked = 0, cyc = 0, n;

  windowed_watchdog_timer windowed_watchdog_timer_inst (.sys_clk_i(sys_clk_i),
    .rst_i(rst_i), .psel_i(psel), .penable_i(pen), .pwrite_i(pwr), .paddr_i(paddr),
    .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
    .watchdog_clear_instr_i(ev[0]), .power_save_instr_i(ev[1]),
    .power_save_idle_i(idle), .wake_event_i(ev[2]), .clock_switch_done_i(ev[3]),
    .wdt_reset_o(wrst), .wake_o(wake), .low_power_rc_osc_en_o(osc),
    .power_mode_o(mode));

  // Clock and hang guard; the run needs about 75000 cycles
  always #50 sys_clk_i = ~sys_clk_i;
  always @(posedge sys_clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 90000) begin
      n_fail++;
      end_sim();
    end
  end

  task automatic end_sim();
    $display("checks %0d failures %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  task automatic cmp(input string nm, input logic [31:0] ex, input logic [31:0] got);
    checked++;
    if (got !== ex) begin
      n_fail++;
      $display("CHECK FAILED %s exp %h got %h", nm, ex, got);
    end
  endtask

  // Request held until pready is seen at an edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk_i);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk_i);
    pen <= 1'b1;
    do @(posedge sys_clk_i); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask

  // One-cycle pulse: 0 clear, 1 power save, 2 wake, 3 clock switch
  task automatic pulse(input int k);
    @(posedge sys_clk_i);
    ev <= 4'h1 << k;
    @(posedge sys_clk_i);
    ev <= 4'h0;
  endtask

  task automatic quiet(input int c);
    n = 0;
    repeat (c) begin
      @(posedge sys_clk_i);
      if (wrst !== 1'b0) n++;
    end
    cmp("no_reset", 0, 32'(n));
  endtask

  // Waits for reset (k=0) or wake (k=1), n counts cycles
  task automatic wait_ev(input int k);
    n = 0;
    do begin
      @(posedge sys_clk_i);
      n++;
    end while ((k == 0 ? wrst : wake) !== 1'b1);
  endtask

  initial begin
    repeat (12) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    apb(0, OFS_CFG, 0); cmp("cfg", CFG_RESET, r);
    apb(0, OFS_CTRL, 0); cmp("ctrl", 0, r);
    cmp("osc", 0, osc);
    apb(0, 8'h10, 0); cmp("err", 1, e);
    cmp("rd_unmapped", 0, r);
    // Window off: early clear harmless, then full div32 period
    apb(1, OFS_CFG, 32'h40);
    apb(1, OFS_CTRL, 1);
    pulse(0);
    quiet(1);
    cmp("osc", 1, osc);
    wait_ev(0);
    cmp("period32", 1, 32'(n > 32 * RC_TICK_DIV - 9 && n < 32 * RC_TICK_DIV + 5));
    apb(0, OFS_CTRL, 0); cmp("ctrl_cut", 0, r);
    apb(1, OFS_STAT, 0);
    apb(0, OFS_STAT, 0); cmp("flag", 1, r[0]);
    apb(1, OFS_STAT, 1);
    apb(0, OFS_STAT, 0); cmp("flag_clr", 0, r[0]);
    // Windowed: clock switch restarts, in-window clear restarts, early clear resets
    apb(1, OFS_CFG, 0);
    apb(1, OFS_CTRL, 1);
    quiet(20 * RC_TICK_DIV);
    pulse(3);
    quiet(28 * RC_TICK_DIV);
    pulse(0);
    quiet(20 * RC_TICK_DIV);
    pulse(0);
    @(posedge sys_clk_i);
    cmp("early", 1, wrst);
    apb(0, OFS_STAT, 0); cmp("early_flag", 1, r[5]);
    // Sleep with div128: keeps counting and wakes
    apb(1, OFS_STAT, 32'h3F);
    apb(1, OFS_CFG, 32'h50);
    apb(1, OFS_CTRL, 1);
    pulse(1);
    @(posedge sys_clk_i);
    cmp("sleep", MODE_SLEEP, mode);
    wait_ev(1);
    cmp("period128", 1, 32'(n > 127 * RC_TICK_DIV - 5 && n < 128 * RC_TICK_DIV + 5));
    repeat (2) @(posedge sys_clk_i);
    cmp("resume", MODE_RUN, mode);
    apb(0, OFS_STAT, 0); cmp("stat", 3, r[1:0]);
    // Idle left by another wake source
    idle <= 1'b1;
    pulse(1);
    @(posedge sys_clk_i);
    cmp("idle", MODE_IDLE, mode);
    pulse(2);
    @(posedge sys_clk_i);
    cmp("idle_exit", MODE_RUN, mode);
    apb(0, OFS_STAT, 0); cmp("idle_flag", 1, r[2]);
    apb(0, OFS_COUNT, 0); cmp("count_mode", 0, r[25:24]);
    // Hard enable overrides soft enable, reset clears soft enable
    apb(1, OFS_CFG, 32'hD0);
    apb(1, OFS_CTRL, 0);
    repeat (3) @(posedge sys_clk_i);
    cmp("hard_osc", 1, osc);
    apb(0, OFS_STAT, 0); cmp("running", 1, r[4]);
    apb(1, OFS_CTRL, 1);
    rst_i <= 1'b1;
    repeat (2) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    apb(0, OFS_CTRL, 0); cmp("ctrl_rst", 0, r);
    cmp("osc_rst", 0, osc);
    end_sim();
  end
endmodule // windowed_watchdog_timer_bench

bind windowed_watchdog_timer wdt_checker wdt_checker_inst (.sys_clk_i, .rst_i, .psel_i,
  .penable_i, .paddr_i, .prdata_o, .pready_o, .pslverr_o, .watchdog_clear_instr_i,
  .wdt_reset_o, .wake_o, .low_power_rc_osc_en_o, .power_mode_o);

`default_nettype wire
